// [design/bbs_blank_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module bbs_blank_timer #(
	parameter int BLANK_CYCLES = bbs_pkg::BBS_BLANK_CYC
) (
	// clock and reset
	input  wire logic clk_in,
	input  wire logic rst_in,
	// control
	input  wire logic start_in,
	// status
	output var  logic blank_out
);
	import bbs_pkg::*;

	logic [BBS_CNT_W-1:0] count;

	// restart on every start_in pulse (each accepted setpoint write)
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			count <= '0;
		end else if (start_in) begin
			count <= BBS_CNT_W'(BLANK_CYCLES);
		end else if (count != '0) begin
			count <= count - 1'b1;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			blank_out <= 1'b0;
		end else begin
			blank_out <= start_in || (count > BBS_CNT_W'(1));
		end
	end
endmodule // bbs_blank_timer
`default_nettype wire

// [design/bbs_pkg.sv]
`default_nettype none
package bbs_pkg;
	localparam int          BBS_ADDR_W      = 8;
	localparam int          BBS_DATA_W      = 32;
	// register index and byte addresses
	localparam logic [7:0]  BBS_SETPOINT_IDX  = 8'h19;
	localparam logic [7:0]  BBS_SETPOINT_ADDR = 8'h64;
	localparam logic [7:0]  BBS_CTRL_ADDR     = 8'h80;
	localparam logic [7:0]  BBS_STAT_ADDR     = 8'h84;
	// setpoint fields
	localparam int          BBS_PSKIP_BIT   = 7;
	localparam int          BBS_RSVD_BIT    = 6;
	localparam int          BBS_CODE_HI     = 5;
	localparam logic [7:0]  BBS_RESET_VAL   = 8'h94;
	localparam logic [5:0]  BBS_CODE_MAX    = 6'h34;
	localparam logic [5:0]  BBS_CODE_RESET  = 6'h14;
	// ctrl/status fields
	localparam int          BBS_UNLOCK_BIT  = 0;
	localparam int          BBS_BLANK_BIT   = 0;
	localparam int          BBS_REJECT_BIT  = 1;
	localparam int          BBS_RSVDCODE_BIT = 2;
	// timing
	localparam int          BBS_CLK_MHZ     = 100;
	localparam int          BBS_BLANK_US    = 5000;
	localparam int          BBS_BLANK_CYC   = BBS_BLANK_US * BBS_CLK_MHZ;
	localparam int          BBS_CNT_W       = 20;
	// wait states
	localparam logic [1:0]  BBS_WAIT_CYC    = 2'h1;
	localparam logic [31:0] BBS_ZERO        = 32'h0;
endpackage : bbs_pkg
`default_nettype wire

// [design/bbs_setpoint_reg.sv]
`timescale 1ns/1ps
`default_nettype none
module bbs_setpoint_reg #(
	parameter int BLANK_CYCLES = bbs_pkg::BBS_BLANK_CYC
) (
	// clock and reset
	input  wire logic                            clk_in,
	input  wire logic                            rst_in,
	// avalon-mm slave
	input  wire logic [bbs_pkg::BBS_ADDR_W-1:0]  avs_address_in,
	input  wire logic                            avs_read_in,
	input  wire logic                            avs_write_in,
	input  wire logic [3:0]                      avs_byteenable_in,
	input  wire logic [bbs_pkg::BBS_DATA_W-1:0]  avs_writedata_in,
	output var  logic [bbs_pkg::BBS_DATA_W-1:0]  avs_readdata_out,
	output var  logic                            avs_waitrequest_out,
	output var  logic [1:0]                      avs_response_out,
	// device side
	input  wire logic                            unlock_in,
	input  wire logic                            default_select_resistor_in,
	input  wire logic [7:0]                      resistor_default_in,
	input  wire logic                            light_load_in,
	// converter controls
	output var  logic [5:0]                      setpoint_code_out,
	output var  logic                            pulse_skip_enable_out,
	output var  logic                            pulse_skip_active_out,
	output var  logic                            monitor_blank_out
);
	import bbs_pkg::*;

	typedef enum logic [1:0] {BBS_IDLE, BBS_WAIT, BBS_DONE} bbs_state_t;

	bbs_state_t state;
	logic [1:0] wait_cnt;
	logic       pulse_skip_enable;
	logic [5:0] setpoint_code;
	logic       loaded;
	logic       ctrl_unlock;
	logic       reject_flag;
	logic       rsvd_code_flag;
	logic       blank;
	logic       req;
	logic       accept;
	logic       sel_set;
	logic       sel_ctrl;
	logic       sel_stat;
	logic       wr_set_ok;
	logic       wr_set_bad;
	logic       clr_flags;

	assign req      = avs_read_in || avs_write_in;
	assign accept   = (state == BBS_WAIT) && (wait_cnt == '0);
	assign sel_set  = avs_address_in == BBS_SETPOINT_ADDR;
	assign sel_ctrl = avs_address_in == BBS_CTRL_ADDR;
	assign sel_stat = avs_address_in == BBS_STAT_ADDR;
	assign wr_set_ok  = accept && avs_write_in && sel_set
		&& avs_byteenable_in[0] && (unlock_in || ctrl_unlock);
	assign wr_set_bad = accept && avs_write_in && sel_set
		&& avs_byteenable_in[0] && !(unlock_in || ctrl_unlock);
	assign clr_flags  = accept && avs_write_in && sel_stat
		&& avs_byteenable_in[0];

	// bus handshake
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state    <= BBS_IDLE;
			wait_cnt <= '0;
		end else begin
			unique case (state)
				BBS_IDLE: begin
					if (req) begin
						state    <= BBS_WAIT;
						wait_cnt <= BBS_WAIT_CYC;
					end
				end
				BBS_WAIT: begin
					if (wait_cnt == '0) begin
						state <= BBS_DONE;
					end else begin
						wait_cnt <= wait_cnt - 1'b1;
					end
				end
				BBS_DONE: begin
					state <= BBS_IDLE;
				end
				default: begin
					state <= BBS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			avs_waitrequest_out <= 1'b1;
		end else begin
			avs_waitrequest_out <= !((state == BBS_WAIT) && (wait_cnt == 2'h1));
		end
	end

	// read data and response
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			avs_readdata_out <= BBS_ZERO;
			avs_response_out <= 2'h0;
		end else if ((state == BBS_WAIT) && (wait_cnt == 2'h1)) begin
			avs_readdata_out <= BBS_ZERO;
			avs_response_out <= 2'h0;
			if (sel_set) begin
				avs_readdata_out[7:0] <= {pulse_skip_enable, 1'b0,
					setpoint_code};
			end else if (sel_ctrl) begin
				avs_readdata_out[BBS_UNLOCK_BIT] <= ctrl_unlock;
			end else if (sel_stat) begin
				avs_readdata_out[BBS_BLANK_BIT]    <= blank;
				avs_readdata_out[BBS_REJECT_BIT]   <= reject_flag;
				avs_readdata_out[BBS_RSVDCODE_BIT] <= rsvd_code_flag;
			end else begin
				avs_response_out <= 2'h2;
			end
		end
	end

	// control register
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ctrl_unlock <= 1'b0;
		end else if (accept && avs_write_in && sel_ctrl
			&& avs_byteenable_in[0]) begin
			ctrl_unlock <= avs_writedata_in[BBS_UNLOCK_BIT];
		end
	end

	// setpoint register
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pulse_skip_enable <= BBS_RESET_VAL[BBS_PSKIP_BIT];
			setpoint_code     <= BBS_RESET_VAL[BBS_CODE_HI:0];
			loaded            <= 1'b0;
		end else if (!loaded) begin
			loaded <= 1'b1;
			if (default_select_resistor_in) begin
				pulse_skip_enable <= resistor_default_in[BBS_PSKIP_BIT];
				setpoint_code     <= resistor_default_in[BBS_CODE_HI:0];
			end
		end else if (wr_set_ok) begin
			pulse_skip_enable <= avs_writedata_in[BBS_PSKIP_BIT];
			setpoint_code     <= avs_writedata_in[BBS_CODE_HI:0];
		end
	end

	// status flags, set wins over clear
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			reject_flag    <= 1'b0;
			rsvd_code_flag <= 1'b0;
		end else begin
			if (wr_set_bad) begin
				reject_flag <= 1'b1;
			end else if (clr_flags && avs_writedata_in[BBS_REJECT_BIT]) begin
				reject_flag <= 1'b0;
			end
			if (wr_set_ok && (avs_writedata_in[BBS_CODE_HI:0] > BBS_CODE_MAX)) begin
				rsvd_code_flag <= 1'b1;
			end else if (clr_flags && avs_writedata_in[BBS_RSVDCODE_BIT]) begin
				rsvd_code_flag <= 1'b0;
			end
		end
	end

	bbs_blank_timer #(
		.BLANK_CYCLES (BLANK_CYCLES)
	) u_blank (
		.clk_in    (clk_in),
		.rst_in    (rst_in),
		.start_in  (wr_set_ok),
		.blank_out (blank)
	);

	// converter outputs
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			setpoint_code_out     <= BBS_CODE_RESET;
			pulse_skip_enable_out <= 1'b1;
			pulse_skip_active_out <= 1'b0;
			monitor_blank_out     <= 1'b0;
		end else begin
			setpoint_code_out     <= setpoint_code;
			pulse_skip_enable_out <= pulse_skip_enable;
			pulse_skip_active_out <= pulse_skip_enable && light_load_in;
			monitor_blank_out     <= blank;
		end
	end

	// blanking cycles seen since the last accepted write
	logic [BBS_CNT_W-1:0] blank_seen;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			blank_seen <= '0;
		end else if (wr_set_ok) begin
			blank_seen <= '0;
		end else if (monitor_blank_out) begin
			blank_seen <= blank_seen + 1'b1;
		end
	end

	// assertions
	write_refused_a: assert property (
		@(posedge clk_in) disable iff (rst_in)
		wr_set_bad |=> $stable(setpoint_code) && $stable(pulse_skip_enable))
		else $error("locked write changed setpoint");
	write_taken_a: assert property (
		@(posedge clk_in) disable iff (rst_in)
		wr_set_ok |=>
		setpoint_code == $past(avs_writedata_in[BBS_CODE_HI:0]))
		else $error("setpoint not stored");
	pskip_taken_a: assert property (
		@(posedge clk_in) disable iff (rst_in)
		wr_set_ok |=>
		pulse_skip_enable == $past(avs_writedata_in[BBS_PSKIP_BIT]))
		else $error("pulse-skip bit not stored");
	blank_start_a: assert property (
		@(posedge clk_in) disable iff (rst_in)
		wr_set_ok |=> ##1 monitor_blank_out [*8])
		else $error("blanking not started");
	reserved_zero_a: assert property (
		@(posedge clk_in) disable iff (rst_in)
		accept && avs_read_in && sel_set |-> !avs_readdata_out[BBS_RSVD_BIT])
		else $error("reserved bit reads one");
	pskip_gate_a: assert property (
		@(posedge clk_in) disable iff (rst_in)
		pulse_skip_active_out |-> $past(pulse_skip_enable && light_load_in))
		else $error("pulse-skip without enable");
	reset_value_a: assert property (
		@(posedge clk_in)
		$fell(rst_in) && !default_select_resistor_in |->
		{pulse_skip_enable, 1'b0, setpoint_code} == BBS_RESET_VAL)
		else $error("wrong reset value");
	strap_load_a: assert property (
		@(posedge clk_in) disable iff (rst_in)
		!loaded && default_select_resistor_in |=>
		setpoint_code == $past(resistor_default_in[BBS_CODE_HI:0]))
		else $error("resistor default not loaded");
	one_wait_a: assert property (
		@(posedge clk_in) disable iff (rst_in)
		state == BBS_IDLE && req |-> ##2 !avs_waitrequest_out)
		else $error("waitrequest not released");
	wait_pulse_a: assert property (
		@(posedge clk_in) disable iff (rst_in)
		!avs_waitrequest_out |=> avs_waitrequest_out)
		else $error("waitrequest low for two cycles");
	idle_wait_a: assert property (
		@(posedge clk_in) disable iff (rst_in)
		state == BBS_IDLE |-> avs_waitrequest_out)
		else $error("waitrequest low while idle");
	unmapped_resp_a: assert property (
		@(posedge clk_in) disable iff (rst_in)
		accept && !(sel_set || sel_ctrl || sel_stat) |->
		avs_response_out == 2'h2 && avs_readdata_out == BBS_ZERO)
		else $error("unmapped access not flagged");
	upper_zero_a: assert property (
		@(posedge clk_in) disable iff (rst_in)
		accept && avs_read_in && sel_set |->
		avs_readdata_out[BBS_DATA_W-1:BBS_PSKIP_BIT+1] == '0)
		else $error("setpoint read has upper bits set");
	strap_off_a: assert property (
		@(posedge clk_in) disable iff (rst_in)
		!loaded && !default_select_resistor_in |=>
		setpoint_code == BBS_RESET_VAL[BBS_CODE_HI:0])
		else $error("reset value lost without resistor default");
	reject_set_a: assert property (
		@(posedge clk_in) disable iff (rst_in)
		wr_set_bad |-> avs_response_out == 2'h0 ##1 reject_flag)
		else $error("refused write not reported");
	rsvd_flag_a: assert property (
		@(posedge clk_in) disable iff (rst_in)
		wr_set_ok && avs_writedata_in[BBS_CODE_HI:0] > BBS_CODE_MAX |=>
		rsvd_code_flag)
		else $error("reserved code not flagged");
	code_follow_a: assert property (
		@(posedge clk_in) disable iff (rst_in)
		setpoint_code_out == $past(setpoint_code))
		else $error("setpoint code output lags");
	pskip_follow_a: assert property (
		@(posedge clk_in) disable iff (rst_in)
		pulse_skip_enable_out == $past(pulse_skip_enable))
		else $error("pulse-skip output lags");
	pskip_off_a: assert property (
		@(posedge clk_in) disable iff (rst_in)
		!pulse_skip_enable_out |-> !pulse_skip_active_out)
		else $error("pulse-skip active while disabled");
	blank_cause_a: assert property (
		@(posedge clk_in) disable iff (rst_in)
		$rose(monitor_blank_out) |-> $past(wr_set_ok, 2))
		else $error("blanking without a write");
	blank_len_a: assert property (
		@(posedge clk_in) disable iff (rst_in)
		$fell(monitor_blank_out) && !$past(wr_set_ok) |->
		blank_seen >= BBS_CNT_W'(BLANK_CYCLES) &&
		blank_seen <= BBS_CNT_W'(BLANK_CYCLES + 1))
		else $error("blanking length wrong");

	write_cov_c: cover property (@(posedge clk_in) disable iff (rst_in) wr_set_ok);
	refuse_cov_c: cover property (@(posedge clk_in) disable iff (rst_in) wr_set_bad);
	rewrite_cov_c: cover property (@(posedge clk_in) disable iff (rst_in)
		wr_set_ok && monitor_blank_out);
	unmapped_cov_c: cover property (@(posedge clk_in) disable iff (rst_in)
		accept && !(sel_set || sel_ctrl || sel_stat));
	strap_cov_c: cover property (@(posedge clk_in) disable iff (rst_in)
		!loaded && default_select_resistor_in);
endmodule // bbs_setpoint_reg
`default_nettype wire

// [dv/bbs_conv_model.sv]
`timescale 1ns/1ps
`default_nettype none
module bbs_conv_model (
	// clock
	input  wire logic clk_in,
	// load from bench
	input  wire logic heavy_in,
	// to block
	output var  logic light_load_out
);
	// load sensing settles one cycle late, as a comparator would
	always_ff @(posedge clk_in) begin
		light_load_out <= !heavy_in;
	end
endmodule // bbs_conv_model
`default_nettype wire

// [dv/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
	import bbs_pkg::*;
	localparam int BL = 20;
	logic        clk_in, rst_in, rd, wr, unl, dsel, heavy, lite;
	logic        pse, psa, blank, wq;
	logic [7:0]  addr;
	logic [5:0]  code;
	logic [1:0]  resp, rs;
	logic [31:0] wd, rd_q, rdat;
	int          n_mismatch, tests_run, i;

	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	bbs_setpoint_reg #(.BLANK_CYCLES(BL)) dut (
		.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(addr),
		.avs_read_in(rd), .avs_write_in(wr), .avs_byteenable_in(4'hf),
		.avs_writedata_in(wd), .avs_readdata_out(rd_q),
		.avs_waitrequest_out(wq), .avs_response_out(resp),
		.unlock_in(unl), .default_select_resistor_in(dsel),
		.resistor_default_in(8'h8a), .light_load_in(lite),
		.setpoint_code_out(code), .pulse_skip_enable_out(pse),
		.pulse_skip_active_out(psa), .monitor_blank_out(blank));
	bbs_conv_model conv (.clk_in(clk_in), .heavy_in(heavy),
		.light_load_out(lite));

	task test_done;
		$display("compares %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch at %0t got %h exp %h", $time, g, e);
		end
	endtask

	task cyc(input int n);
		repeat (n) @(posedge clk_in);
	endtask

	// one avalon transfer, held until waitrequest is sampled low
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_in);
		rd <= !w;
		wr <= w;
		addr <= a;
		wd <= d;
		for (k = 0; k < 20; k++) begin
			@(posedge clk_in);
			if (wq === 1'b0)
				break;
		end
		if (k == 20) begin
			n_mismatch++;
			$display("mismatch at %0t waitrequest %h exp %h", $time, wq, 1'b0);
			test_done();
		end
		rdat = rd_q;
		rs = resp;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	task reset(input logic s);
		rst_in <= 1'b1;
		dsel <= s;
		cyc(16);
		rst_in <= 1'b0;
		cyc(2);
	endtask

	initial begin
		rst_in = 1'b1; rd = 1'b0; wr = 1'b0; addr = 8'h0; wd = 32'h0;
		unl = 1'b0; dsel = 1'b0; heavy = 1'b1;
		n_mismatch = 0; tests_run = 0;
		reset(1'b0);
		bus(1'b0, BBS_SETPOINT_ADDR, 32'h0);
		chk(rdat, 32'h94);
		chk({pse, code}, 32'h54);
		$display("test 1 done");
		bus(1'b1, BBS_SETPOINT_ADDR, 32'h01);
		bus(1'b0, BBS_SETPOINT_ADDR, 32'h0);
		chk(rdat, 32'h94);
		bus(1'b0, BBS_STAT_ADDR, 32'h0);
		chk(rdat & 32'h2, 32'h2);
		chk(blank, 32'h0);
		bus(1'b1, BBS_STAT_ADDR, 32'h2);
		bus(1'b0, BBS_STAT_ADDR, 32'h0);
		chk(rdat & 32'h2, 32'h0);
		$display("test 2 done");
		unl <= 1'b1;
		// monitor blanked while code changes
		bus(1'b1, BBS_SETPOINT_ADDR, 32'h7f);
		cyc(3);
		for (i = 0; i < 3 * BL && blank === 1'b1; i++)
			cyc(1);
		chk(i >= BL - 3 && i <= BL + 3, 32'h1);
		bus(1'b0, BBS_SETPOINT_ADDR, 32'h0);
		chk(rdat, 32'h3f);
		chk({pse, code}, 32'h3f);
		bus(1'b0, BBS_STAT_ADDR, 32'h0);
		chk(rdat & 32'h4, 32'h4);
		$display("test 3 done");
		bus(1'b1, BBS_SETPOINT_ADDR, 32'hb4);
		heavy <= 1'b0;
		cyc(4);
		chk(psa, 32'h1);
		heavy <= 1'b1;
		cyc(4);
		chk(psa, 32'h0);
		bus(1'b1, BBS_SETPOINT_ADDR, 32'h34);
		heavy <= 1'b0;
		cyc(4);
		chk({psa, pse, code}, 32'h34);
		$display("test 4 done");
		bus(1'b0, 8'h10, 32'h0);
		chk(rs, 32'h2);
		chk(rdat, 32'h0);
		bus(1'b1, 8'h10, 32'hff);
		chk(rs, 32'h2);
		unl <= 1'b0;
		bus(1'b1, BBS_CTRL_ADDR, 32'h1);
		bus(1'b1, BBS_SETPOINT_ADDR, 32'h85);
		bus(1'b0, BBS_SETPOINT_ADDR, 32'h0);
		chk(rdat, 32'h85);
		$display("test 5 done");
		reset(1'b1);
		bus(1'b0, BBS_SETPOINT_ADDR, 32'h0);
		chk(rdat, 32'h8a);
		$display("test 6 done");
		test_done();
	end
endmodule // tb
`default_nettype wire
